/* rtl/sep_ctrl.sv */
/*
 * Serial EEPROM pin control: bus slave front end, strap match,
 * write protect, open-drain data, supply-gated reset, write cycle.
 * Assumes scl/sda come from the bus pins with external pull-up and
 * that unconnected strap and write-protect pads are pulled low.
 */
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - straps compared with device select bits b3..b1 as sub-address.
// - an open strap pad reads as 0.
// - write protect high blocks every array write.
// - write protect low or open allows array writes.
// - with protect high, select and address acked, data bytes not.
// - scl samples incoming data and times outgoing data.
// - data line only pulled low or released.
// - bus ignored until supply passes reset threshold.
// - crossing the threshold resets state into standby.
// - supply below threshold stops all responses.
// - a Stop with no write cycle pending enters standby.
// - main array of 65536 bytes, 16-bit address.
// - separate 128-byte identification page.
// - identification page lock makes it read-only until nrst goes low.
// - select match acks in ninth clock; mismatch releases to standby.
// - write cycle starts only on Stop right after data ack slot.
// - during write cycle data line off and all requests ignored.
// - select bit 0 picks direction, 1 read, 0 write.
module sep_ctrl
    import sep_pkg::*;
#(
    parameter int unsigned WR_CYCLES = WRITE_CYCLES,
    // arbitrary neutral device type codes
    parameter logic [3:0] MEM_TYPE = 4'h5,
    parameter logic [3:0] ID_TYPE = 4'h6
) (
    input wire logic mclk,             // 200 MHz clock
    input wire logic nrst,             // sync reset, active low
    input wire logic scl_in,           // bus clock pin
    input wire logic sda_in,           // bus data pin level
    output logic sda_out,              // data drive level, always low
    output logic sda_oe,               // high pulls data line low
    input wire logic strap_addr_bit2,  // sub-address strap
    input wire logic strap_addr_bit1,  // sub-address strap
    input wire logic strap_addr_bit0,  // sub-address strap
    input wire logic write_protect_in, // high blocks array writes
    input wire logic supply_ok_in,     // supply above reset threshold
    output logic standby,              // standby power mode
    output logic write_busy,           // internal write cycle running
    output logic id_locked             // identification page locked
);
    localparam int unsigned CNT_W = $clog2(WR_CYCLES + 1);

    logic [6:0] s1_q, s2_q, s3_q, pin_q, prev_q, agree;
    sep_pins_t pin, prev;
    sep_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q, tx_q, rd_byte;
    logic [ADDR_W-1:0] addr_q;
    logic id_sel_q, sda_oe_q, slot10_q, wr_pend_q, lock_pend_q, lock_q;
    logic [CNT_W-1:0] wcnt_q;
    logic [ID_DEPTH-1:0] mask_q;
    logic [7:0] buf_q [ID_DEPTH];
    logic [7:0] mem [MEM_DEPTH];
    logic [7:0] id_mem [ID_DEPTH];
    logic active_rst, scl_rise, scl_fall, start_ev, stop_ev;
    logic byte_done, dev_match, data_ok, lock_instr, data_take;
    logic wr_go, wc_done;

    // ---------------------------------------------------------------
    // pin synchronisers, change taken when stages two and three agree
    // ---------------------------------------------------------------
    // open straps seen as 0, stages reset to PINS_IDLE with scl and sda high
    assign agree = ~(s2_q ^ s3_q);
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s1_q <= PINS_IDLE;
            s2_q <= PINS_IDLE;
            s3_q <= PINS_IDLE;
            pin_q <= PINS_IDLE;
            prev_q <= PINS_IDLE;
        end else begin
            s1_q <= {scl_in, sda_in, supply_ok_in, write_protect_in,
                     strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= (pin_q & ~agree) | (s3_q & agree);
            prev_q <= pin_q;
        end
    end
    assign pin = sep_pins_t'(pin_q);
    assign prev = sep_pins_t'(prev_q);

    // ---------------------------------------------------------------
    // bus events
    // ---------------------------------------------------------------
    // scl edges time all sampling
    assign scl_rise = pin.scl & ~prev.scl;
    assign scl_fall = ~pin.scl & prev.scl;
    assign start_ev = pin.scl & prev.scl & prev.sda & ~pin.sda;
    assign stop_ev = pin.scl & prev.scl & ~prev.sda & pin.sda;
    // held in reset below supply threshold
    // low supply silences the bus side
    assign active_rst = ~nrst | ~pin.supply_ok;
    assign byte_done = scl_fall & (cnt_q == LAST_BIT) & ~start_ev
        & ~stop_ev & (state_q != ST_WCYCLE);
    // straps read live at the select decision
    assign dev_match = ((shift_q[7:4] == MEM_TYPE)
        | (shift_q[7:4] == ID_TYPE)) & (shift_q[3:1] == pin.strap);
    // protect and lock gate data acceptance
    // protect low or open accepts data
    assign data_ok = ~pin.wp & ~(id_sel_q & lock_q);
    assign lock_instr = id_sel_q & addr_q[LOCK_ADDR_BIT];
    assign data_take = byte_done & (state_q == ST_WDATA) & data_ok
        & ~lock_instr;
    // write only on Stop in the tenth slot
    assign wr_go = (state_q == ST_WDATA) & stop_ev & slot10_q
        & wr_pend_q;
    assign wc_done = (state_q == ST_WCYCLE) & (wcnt_q == '0);
    assign rd_byte = id_sel_q ? id_mem[addr_q[PAGE_W-1:0]] : mem[addr_q];

    // ---------------------------------------------------------------
    // protocol engine
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (active_rst) begin
            state_q <= ST_STANDBY;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'hFF;
            addr_q <= '0;
            id_sel_q <= 1'b0;
            sda_oe_q <= 1'b0;
            slot10_q <= 1'b0;
            wr_pend_q <= 1'b0;
            lock_pend_q <= 1'b0;
        end else if (state_q == ST_WCYCLE) begin
            sda_oe_q <= 1'b0;
            if (wc_done) begin
                state_q <= ST_STANDBY;
            end
        end else if (stop_ev) begin
            sda_oe_q <= 1'b0;
            cnt_q <= 4'h0;
            slot10_q <= 1'b0;
            state_q <= wr_go ? ST_WCYCLE : ST_STANDBY;
        end else if (start_ev) begin
            sda_oe_q <= 1'b0;
            // scl fall closing the start brings count to zero
            cnt_q <= 4'hF;
            slot10_q <= 1'b0;
            state_q <= ST_DEVSEL;
        end else if (state_q != ST_STANDBY) begin
            if (scl_rise) begin
                if (cnt_q != ACK_SLOT) begin
                    shift_q <= {shift_q[6:0], pin.sda};
                end else if (state_q == ST_RDATA && pin.sda) begin
                    state_q <= ST_RWAIT;
                end
            end
            if (byte_done) begin
                cnt_q <= ACK_SLOT;
                case (state_q)
                    ST_DEVSEL: begin
                        // ack on match, drop out on mismatch
                        if (dev_match) begin
                            sda_oe_q <= 1'b1;
                            id_sel_q <= (shift_q[7:4] == ID_TYPE);
                            state_q <= shift_q[0] ? ST_RDATA : ST_ADDR_HI;
                        end else begin
                            state_q <= ST_STANDBY;
                        end
                    end
                    ST_ADDR_HI: begin
                        sda_oe_q <= 1'b1;
                        addr_q[15:8] <= shift_q;
                        state_q <= ST_ADDR_LO;
                    end
                    ST_ADDR_LO: begin
                        sda_oe_q <= 1'b1;
                        addr_q[7:0] <= shift_q;
                        wr_pend_q <= 1'b0;
                        lock_pend_q <= 1'b0;
                        state_q <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        sda_oe_q <= data_ok;
                        if (data_ok) begin
                            wr_pend_q <= 1'b1;
                            lock_pend_q <= lock_pend_q | lock_instr;
                            addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0]
                                + 7'h01;
                        end
                    end
                    default: begin
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end else if (scl_fall && cnt_q == ACK_SLOT) begin
                cnt_q <= 4'h0;
                slot10_q <= (state_q == ST_WDATA);
                if (state_q == ST_RDATA) begin
                    // outgoing bit changes on scl fall
                    sda_oe_q <= ~rd_byte[7];
                    tx_q <= {rd_byte[6:0], 1'b1};
                    addr_q <= addr_q + 16'h0001;
                end else begin
                    sda_oe_q <= 1'b0;
                end
            end else if (scl_fall) begin
                // slot ten ends once a further bit is clocked, or at a Start or Stop
                slot10_q <= 1'b0;
                cnt_q <= cnt_q + 4'h1;
                if (state_q == ST_RDATA) begin
                    sda_oe_q <= ~tx_q[7];
                    tx_q <= {tx_q[6:0], 1'b1};
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // page buffer
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (active_rst) begin
            mask_q <= '0;
        end else if (byte_done && state_q == ST_ADDR_LO) begin
            mask_q <= '0;
        end else if (data_take) begin
            mask_q[addr_q[PAGE_W-1:0]] <= 1'b1;
            buf_q[addr_q[PAGE_W-1:0]] <= shift_q;
        end
    end

    // ---------------------------------------------------------------
    // write cycle timer
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (active_rst) begin
            wcnt_q <= '0;
        end else if (wr_go) begin
            wcnt_q <= CNT_W'(WR_CYCLES - 1);
        end else if (wcnt_q != '0) begin
            wcnt_q <= wcnt_q - CNT_W'(1);
        end
    end

    // ---------------------------------------------------------------
    // array commit and page lock
    // ---------------------------------------------------------------
    // main array; identification page
    always_ff @(posedge mclk) begin
        if (wc_done && !id_sel_q) begin
            for (int i = 0; i < ID_DEPTH; i++) begin
                if (mask_q[i]) begin
                    mem[{addr_q[15:PAGE_W], PAGE_W'(i)}] <= buf_q[i];
                end
            end
        end
        if (wc_done && id_sel_q && !lock_q) begin
            for (int i = 0; i < ID_DEPTH; i++) begin
                if (mask_q[i]) begin
                    id_mem[i] <= buf_q[i];
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            lock_q <= 1'b0;
        end else if (wc_done && lock_pend_q) begin
            lock_q <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // open drain, low or released only
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_q;
    assign standby = (state_q == ST_STANDBY);
    assign write_busy = (state_q == ST_WCYCLE);
    assign id_locked = lock_q;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_sel_ack;
        byte_done && state_q == ST_DEVSEL && dev_match |=> sda_oe_q;
    endproperty
    a_sel_ack: assert property (p_sel_ack)
        else $error("select match not acked");

    property p_sel_miss;
        byte_done && state_q == ST_DEVSEL && !dev_match
            |=> standby && !sda_oe_q;
    endproperty
    a_sel_miss: assert property (p_sel_miss)
        else $error("select mismatch not released");

    property p_wp_nack;
        byte_done && state_q == ST_WDATA && pin.wp |=> !sda_oe_q;
    endproperty
    a_wp_nack: assert property (p_wp_nack)
        else $error("data byte acked under protect");

    property p_wp_keep;
        byte_done && state_q == ST_WDATA && pin.wp |=> $stable(mask_q);
    endproperty
    a_wp_keep: assert property (p_wp_keep)
        else $error("protected byte buffered");

    property p_busy_quiet;
        write_busy |-> !sda_oe_q;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("data driven during write cycle");

    property p_wr_start;
        $rose(write_busy) |-> $past(slot10_q) && $past(stop_ev);
    endproperty
    a_wr_start: assert property (p_wr_start)
        else $error("write cycle began outside slot ten");

    property p_supply_off;
        !pin.supply_ok |=> standby && !sda_oe_q;
    endproperty
    a_supply_off: assert property (p_supply_off)
        else $error("active below supply threshold");

    property p_stop_idle;
        stop_ev && !active_rst && !write_busy && !wr_go |=> standby;
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("no standby after stop");

    property p_dir_read;
        byte_done && state_q == ST_DEVSEL && dev_match && shift_q[0]
            |=> state_q == ST_RDATA;
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("read direction not taken");

    property p_lock_nack;
        byte_done && state_q == ST_WDATA && id_sel_q && lock_q
            |=> !sda_oe_q;
    endproperty
    a_lock_nack: assert property (p_lock_nack)
        else $error("locked page byte acked");

    c_sel_ack: cover property (p_sel_ack);
    c_wr_cycle: cover property (wr_go ##1 write_busy);
    c_rd_nack: cover property (state_q == ST_RDATA ##1
        state_q == ST_RWAIT);
endmodule : sep_ctrl

`default_nettype wire

/* rtl/sep_pkg.sv */
/*
 * Shared constants, states and pin carrier for the serial EEPROM
 * pin control block.
 * Assumes a single 200 MHz clock and synchronous active-low reset.
 */
package sep_pkg;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_FREQ_MHZ = 200;
    localparam int unsigned WRITE_TIME_US = 5000;
    localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * CLK_FREQ_MHZ;
    // ---------------------------------------------------------------
    // array and frame layout
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned MEM_DEPTH = 65536;
    localparam int unsigned PAGE_W = 7;
    localparam int unsigned ID_DEPTH = 128;
    localparam int unsigned LOCK_ADDR_BIT = 10;
    localparam int unsigned TYPE_LSB = 4;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_STANDBY, ST_DEVSEL, ST_ADDR_HI, ST_ADDR_LO,
        ST_WDATA, ST_RDATA, ST_RWAIT, ST_WCYCLE
    } sep_state_t;
    typedef struct packed {
        logic scl;
        logic sda;
        logic supply_ok;
        logic wp;
        logic [2:0] strap;
    } sep_pins_t;
    localparam sep_pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1,
        supply_ok: 1'b0, wp: 1'b0, strap: 3'h0};
endpackage : sep_pkg

/* tb/sep_master.sv */
/*
 * Bus master model driving the clock and data lines.
 * Assumes the bench resolves the data wire with a pull-up.
 */
`timescale 1ns/10ps
`default_nettype none
module sep_master #(
    parameter int PHASE = 67
) (
    input wire logic mclk,     // bench clock
    input wire logic sda_line, // resolved data wire
    output logic scl_o,        // bus clock
    output logic sda_o         // data drive, 1 = released
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // three phases a bit, under 1 MHz
    task automatic half();
        repeat (PHASE) @(negedge mclk);
    endtask : half
    task automatic start();
        sda_o = 1'b1;
        half();
        scl_o = 1'b1;
        half();
        sda_o = 1'b0;
        half();
        scl_o = 1'b0;
        half();
    endtask : start
    task automatic stop();
        sda_o = 1'b0;
        half();
        scl_o = 1'b1;
        half();
        sda_o = 1'b1;
        half();
    endtask : stop
    // data moves only while clock low
    task automatic xfer_bit(input logic b, output logic s);
        sda_o = b;
        half();
        scl_o = 1'b1;
        half();
        s = sda_line;
        scl_o = 1'b0;
        half();
    endtask : xfer_bit
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) xfer_bit(d[i], s);
        xfer_bit(1'b1, s);
        ack = ~s;
    endtask : wr_byte
    task automatic rd_byte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
        xfer_bit(~more, s);
    endtask : rd_byte
endmodule : sep_master
`default_nettype wire

/* tb/testbench.sv */
/*
 * Self-checking bench for the serial EEPROM pin control block.
 * Assumes sep_ctrl and the sep_master partner model.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sep_pkg::*;
    localparam int WR_CYC = 3000;
    // arbitrary type codes
    localparam logic [3:0] MEM_T = 4'h5;
    localparam logic [3:0] ID_T = 4'h6;
    logic mclk, nrst, sda_out, sda_oe, standby, write_busy, id_locked;
    logic scl_m, sda_m, sda_line;
    logic [7:0] d;
    sep_pins_t pins;
    int miscompares, comparisons;
    assign sda_line = sda_m & ~(sda_oe & ~sda_out);
    sep_ctrl #(.WR_CYCLES(WR_CYC), .MEM_TYPE(MEM_T), .ID_TYPE(ID_T)) dut (
        .mclk(mclk), .nrst(nrst), .scl_in(scl_m), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .strap_addr_bit2(pins.strap[2]), .strap_addr_bit1(pins.strap[1]),
        .strap_addr_bit0(pins.strap[0]), .write_protect_in(pins.wp),
        .supply_ok_in(pins.supply_ok), .standby(standby),
        .write_busy(write_busy), .id_locked(id_locked));
    sep_master #(.PHASE(67)) master (.mclk(mclk), .sda_line(sda_line),
        .scl_o(scl_m), .sda_o(sda_m));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : chk
    function automatic logic [7:0] sel(input logic [3:0] t, input logic rd);
        return {t, pins.strap, rd};
    endfunction : sel
    task automatic send(input logic [7:0] v, input logic e, input string w);
        logic a;
        master.wr_byte(v, a);
        chk(w, {7'h0, e}, {7'h0, a});
    endtask : send
    task automatic idle(input string w, input logic busy);
        repeat (10) @(negedge mclk);
        chk(w, {7'h0, busy}, {7'h0, write_busy});
    endtask : idle
    task automatic write_at(input logic [15:0] a, input logic [7:0] v,
                            input logic dack);
        master.start();
        send(sel(MEM_T, 1'b0), 1'b1, "sel_w");
        send(a[15:8], 1'b1, "addr_hi");
        send(a[7:0], 1'b1, "addr_lo");
        send(v, dack, "data_ack");
        master.stop();
    endtask : write_at
    task automatic read_at(input logic [15:0] a, output logic [7:0] v);
        master.start();
        send(sel(MEM_T, 1'b0), 1'b1, "sel_w");
        send(a[15:8], 1'b1, "addr_hi");
        send(a[7:0], 1'b1, "addr_lo");
        master.start();
        send(sel(MEM_T, 1'b1), 1'b1, "sel_r");
        master.rd_byte(1'b0, v);
        master.stop();
    endtask : read_at
    task automatic wait_done();
        for (int i = 0; i < WR_CYC + 200 && write_busy !== 1'b0; i++)
            @(negedge mclk);
        chk("write_busy_end", 8'h0, {7'h0, write_busy});
        chk("standby", 8'h1, {7'h0, standby});
    endtask : wait_done
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_write_read();
        pins.strap = 3'h5;
        write_at(16'h12B4, 8'hC3, 1'b1);
        idle("write_busy", 1'b1);
        wait_done();
        read_at(16'h12B4, d);
        chk("read_data", 8'hC3, d);
        chk("sda_out", 8'h0, {7'h0, sda_out});
        $display("test write_read done");
    endtask : t_write_read
    task automatic t_mismatch();
        pins.strap = 3'h0;
        repeat (10) @(negedge mclk);
        master.start();
        send({MEM_T, 3'h1, 1'b0}, 1'b0, "sel_mismatch");
        chk("standby", 8'h1, {7'h0, standby});
        master.stop();
        master.start();
        send(sel(MEM_T, 1'b0), 1'b1, "sel_open");
        send(8'h00, 1'b1, "addr_hi");
        master.stop();
        idle("write_busy", 1'b0);
        chk("standby", 8'h1, {7'h0, standby});
        $display("test mismatch done");
    endtask : t_mismatch
    task automatic t_protect();
        pins.strap = 3'h5;
        pins.wp = 1'b1;
        write_at(16'h12B4, 8'h3C, 1'b0);
        idle("write_busy", 1'b0);
        pins.wp = 1'b0;
        read_at(16'h12B4, d);
        chk("read_kept", 8'hC3, d);
        $display("test protect done");
    endtask : t_protect
    task automatic t_busy();
        write_at(16'h0042, 8'h5A, 1'b1);
        master.start();
        send(sel(MEM_T, 1'b0), 1'b0, "sel_busy");
        master.stop();
        wait_done();
        $display("test busy done");
    endtask : t_busy
    task automatic t_supply();
        // supply drops only after a Stop
        pins.supply_ok = 1'b0;
        repeat (10) @(negedge mclk);
        master.start();
        send(sel(MEM_T, 1'b0), 1'b0, "sel_nosupply");
        master.stop();
        pins.supply_ok = 1'b1;
        repeat (10) @(negedge mclk);
        chk("standby", 8'h1, {7'h0, standby});
        master.start();
        send(sel(MEM_T, 1'b0), 1'b1, "sel_powered");
        master.stop();
        $display("test supply done");
    endtask : t_supply
    task automatic t_idlock();
        master.start();
        send(sel(ID_T, 1'b0), 1'b1, "id_sel");
        send(8'h04, 1'b1, "id_lock_hi");
        send(8'h00, 1'b1, "id_lock_lo");
        send(8'hA5, 1'b1, "id_lock_data");
        master.stop();
        wait_done();
        chk("id_locked", 8'h1, {7'h0, id_locked});
        master.start();
        send(sel(ID_T, 1'b0), 1'b1, "id_sel");
        send(8'h00, 1'b1, "id_addr_hi");
        send(8'h05, 1'b1, "id_addr_lo");
        send(8'h77, 1'b0, "id_data_locked");
        master.stop();
        idle("write_busy", 1'b0);
        $display("test idlock done");
    endtask : t_idlock
    // ---------------------------------------------------------------
    // run control
    // ---------------------------------------------------------------
    task automatic wrap_up();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        miscompares = 0;
        comparisons = 0;
        nrst = 1'b0;
        pins = PINS_IDLE;
        repeat (20) @(negedge mclk);
        chk("sda_oe_reset", 8'h0, {7'h0, sda_oe});
        nrst = 1'b1;
        pins.supply_ok = 1'b1;
        repeat (20) @(negedge mclk);
        chk("standby_reset", 8'h1, {7'h0, standby});
        t_write_read();
        t_mismatch();
        t_protect();
        t_busy();
        t_supply();
        t_idlock();
        wrap_up();
    end
    initial begin
        #480000;
        miscompares++;
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
